// [hdl/dsm_core_mem.v]
// audio core memories, safeload buffer, sample format and stream sequencer
// Functional notes
// - samples are 24 bits in and out
// - input sign-extended to 28 bits
// - data and parameters are signed 5.23
// - output clipped to 24 bits, -1..+1
// - 1024 instructions run every sample period
// - rate setting cuts count for 2x/4x rates
// - parameter ram 1024x32 at 0..1023
// - program ram 1024x40 at 0x400..0x7ff
// - parameter padded with four top zeros
// - unity is word 0x00800000
// - everything zero after power-up except program
// - memories boot-filled before core starts
// - default program passes inputs, outputs muted
// - host reads/writes any location, bursts too
// - direct writes steal parameter ram, no handshake
// - five safeload address/data entries
// - safeload copies only while ram idle
// - safeload targets parameter ram only
// - burst address increments across regions
`timescale 1ns/100ps
`include "dsm_consts.vh"
module dsm_core_mem (
   input wire ref_clk, // 100 mhz core clock
   input wire rst_n, // synchronous reset, active low
   input wire frame_start, // one-cycle pulse at each sample period
   input wire [1:0] rate_sel, // instruction budget select
   input wire clear_regs, // high passes core results to the outputs, low holds output at zero
   input wire [23:0] in_left, // serial input sample left
   input wire [23:0] in_right, // serial input sample right
   input wire host_start, // pulse: latch start address
   input wire [10:0] host_addr, // start address of access
   input wire host_wr, // pulse: write data at current address
   input wire host_rd, // pulse: read data at current address
   input wire [39:0] host_wdata, // write data, low bits used for params
   input wire sl_load, // pulse: load safeload entry
   input wire [2:0] sl_index, // safeload entry number 0..4
   input wire [9:0] sl_addr, // safeload parameter address
   input wire [31:0] sl_data, // safeload parameter data
   input wire sl_commit, // pulse: request commit of loaded entries
   output reg [39:0] host_rdata, // read data
   output reg host_rvalid, // pulse: read data valid
   output reg [23:0] out_left, // clipped output left
   output reg [23:0] out_right, // clipped output right
   output reg out_valid, // pulse: new output sample
   output reg core_ready, // boot done, core running
   output reg sl_pending // safeload entries waiting to commit
);
   // ======================================================
   // functions
   // sign extend a 24 bit sample to the core width
   function [27:0] sext;
      input [23:0] s;
      begin
         sext = {{`DSM_HEADROOM{s[23]}}, s};
      end
   endfunction

   // saturate a 5.23 value into 1.23; top four bits dropped
   function [23:0] clip;
      input [27:0] v;
      begin
         if (!v[27] && (v[26:23] != 4'h0))
         begin
            clip = `DSM_SAT_POS;
         end
         else if (v[27] && (v[26:23] != 4'hf))
         begin
            clip = `DSM_SAT_NEG;
         end
         else
         begin
            clip = v[23:0];
         end
      end
   endfunction

   // signed 5.23 multiply, keep 5.23 with saturation
   function [27:0] fmul;
      input [27:0] a;
      input [27:0] b;
      reg [55:0] p;
      begin
         p = $signed(a) * $signed(b);
         if (!p[55] && (p[54:50] != 5'h00))
         begin
            fmul = 28'h7ffffff;
         end
         else if (p[55] && (p[54:50] != 5'h1f))
         begin
            fmul = 28'h8000000;
         end
         else
         begin
            fmul = p[50:23];
         end
      end
   endfunction

   // ======================================================
   // state
   localparam S_BOOT = 4'b0001;
   localparam S_IDLE = 4'b0010;
   localparam S_RUN = 4'b0100;
   localparam S_SLOAD = 4'b1000;

   reg [3:0] state_reg;
   reg [10:0] boot_cnt_reg;
   reg [10:0] pc_reg;
   reg [10:0] budget_reg;
   reg [10:0] haddr_reg;
   reg hrd_reg;
   reg hrd_prog_reg;
   reg [2:0] sl_ptr_reg;
   reg [4:0] sl_valid_reg;
   reg [9:0] sl_a_reg [0:4];
   reg [31:0] sl_d_reg [0:4];
   reg [27:0] acc_l_reg;
   reg [27:0] acc_r_reg;
   reg [27:0] in_l_reg;
   reg [27:0] in_r_reg;
   reg [1:0] fetch_reg;
   reg [10:0] budget_next;
   integer i;

   // ======================================================
   // memory port arbitration
   wire boot_w = state_reg == S_BOOT;
   wire h_param = (haddr_reg <= `DSM_PARAM_LAST);
   wire h_wr_param = host_wr && h_param && core_ready;
   wire h_wr_prog = host_wr && !h_param && core_ready;
   wire sl_w = (state_reg == S_SLOAD) && sl_valid_reg[sl_ptr_reg];

   // direct host access wins over the core with no handshake
   reg p_we;
   reg [9:0] p_addr;
   reg [31:0] p_wdata;
   always @*
   begin
      p_we = 1'b0;
      p_addr = pc_reg[9:0];
      p_wdata = 32'h0;
      if (boot_w)
      begin
         p_we = 1'b1;
         p_addr = boot_cnt_reg[9:0];
      end
      else if (h_wr_param || (host_rd && h_param))
      begin
         p_we = h_wr_param;
         p_addr = haddr_reg[9:0];
         p_wdata = {4'h0, host_wdata[27:0]};
      end
      else if (sl_w)
      begin
         p_we = 1'b1;
         p_addr = sl_a_reg[sl_ptr_reg];
         p_wdata = {4'h0, sl_d_reg[sl_ptr_reg][27:0]};
      end
   end

   reg g_we;
   reg [9:0] g_addr;
   reg [39:0] g_wdata;
   always @*
   begin
      g_we = 1'b0;
      g_addr = pc_reg[9:0];
      g_wdata = 40'h0;
      if (boot_w)
      begin
         g_we = 1'b1;
         g_addr = boot_cnt_reg[9:0];
         // default pass-through program, rest are no-ops
         if (boot_cnt_reg == 11'h000)
         begin
            g_wdata = {`DSM_OP_PASS_L, 32'h0};
         end
         else if (boot_cnt_reg == 11'h001)
         begin
            g_wdata = {`DSM_OP_PASS_R, 32'h0};
         end
      end
      else if (h_wr_prog || (host_rd && !h_param))
      begin
         g_we = h_wr_prog;
         g_addr = haddr_reg[9:0];
         g_wdata = host_wdata;
      end
   end

   wire [31:0] p_rdata;
   wire [39:0] g_rdata;

   dsm_ram #(.DW(`DSM_PARAM_W), .AW(`DSM_MEM_AW)) u_param (
      .ref_clk(ref_clk),
      .we(p_we),
      .addr(p_addr),
      .wdata(p_wdata),
      .rdata(p_rdata)
   );

   dsm_ram #(.DW(`DSM_PROG_W), .AW(`DSM_MEM_AW)) u_prog (
      .ref_clk(ref_clk),
      .we(g_we),
      .addr(g_addr),
      .wdata(g_wdata),
      .rdata(g_rdata)
   );

   // ======================================================
   // instruction budget from rate select
   always @*
   begin
      case (rate_sel)
         `DSM_RATE_DOUBLE: budget_next = `DSM_INSTR_DOUBLE;
         `DSM_RATE_QUAD: budget_next = `DSM_INSTR_QUAD;
         default: budget_next = `DSM_INSTR_FULL;
      endcase
   end

   // ======================================================
   // host address pointer and read return
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         haddr_reg <= 11'h000;
         hrd_reg <= 1'b0;
         hrd_prog_reg <= 1'b0;
         host_rdata <= 40'h0;
         host_rvalid <= 1'b0;
      end
      else
      begin
         hrd_reg <= host_rd && core_ready;
         hrd_prog_reg <= !h_param;
         host_rvalid <= hrd_reg;
         if (hrd_reg)
         begin
            host_rdata <= hrd_prog_reg ? g_rdata : {8'h00, p_rdata};
         end
         if (host_start)
         begin
            haddr_reg <= host_addr;
         end
         else if ((host_wr || host_rd) && core_ready)
         begin
            haddr_reg <= haddr_reg + 11'h001;
         end
      end
   end

   // ======================================================
   // safeload buffer
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sl_valid_reg <= 5'h00;
         sl_pending <= 1'b0;
         for (i = 0; i < `DSM_SL_DEPTH; i = i + 1)
         begin
            sl_a_reg[i] <= 10'h000;
            sl_d_reg[i] <= 32'h0;
         end
      end
      else
      begin
         if (sl_load && (sl_index < `DSM_SL_DEPTH) && (state_reg != S_SLOAD))
         begin
            sl_a_reg[sl_index] <= sl_addr;
            sl_d_reg[sl_index] <= sl_data;
            sl_valid_reg[sl_index] <= 1'b1;
         end
         if (sl_commit)
         begin
            sl_pending <= 1'b1;
         end
         // all entries drain in one idle window
         if ((state_reg == S_SLOAD) && (sl_ptr_reg == 3'd4))
         begin
            sl_valid_reg <= 5'h00;
            sl_pending <= sl_commit;
         end
      end
   end

   // ======================================================
   // stream sequencer: boot, run, idle, safeload
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= S_BOOT;
         boot_cnt_reg <= 11'h000;
         pc_reg <= 11'h000;
         budget_reg <= `DSM_INSTR_FULL;
         sl_ptr_reg <= 3'd0;
         core_ready <= 1'b0;
         fetch_reg <= 2'b00;
         acc_l_reg <= 28'h0;
         acc_r_reg <= 28'h0;
         in_l_reg <= 28'h0;
         in_r_reg <= 28'h0;
         out_left <= 24'h0;
         out_right <= 24'h0;
         out_valid <= 1'b0;
      end
      else
      begin
         out_valid <= 1'b0;
         fetch_reg <= {fetch_reg[0], state_reg == S_RUN};
         case (state_reg)
            S_BOOT:
            begin
               boot_cnt_reg <= boot_cnt_reg + 11'h001;
               if (boot_cnt_reg == `DSM_PARAM_LAST)
               begin
                  state_reg <= S_IDLE;
                  core_ready <= 1'b1;
               end
            end
            S_IDLE:
            begin
               if (frame_start)
               begin
                  in_l_reg <= sext(in_left);
                  in_r_reg <= sext(in_right);
                  acc_l_reg <= 28'h0;
                  acc_r_reg <= 28'h0;
                  budget_reg <= budget_next;
                  pc_reg <= 11'h000;
                  state_reg <= S_RUN;
               end
               else if (sl_pending)
               begin
                  sl_ptr_reg <= 3'd0;
                  state_reg <= S_SLOAD;
               end
            end
            S_RUN:
            begin
               pc_reg <= pc_reg + 11'h001;
               if (pc_reg == budget_reg - 11'h001)
               begin
                  state_reg <= S_IDLE;
               end
            end
            S_SLOAD:
            begin
               // core is idle here, so ram writes cannot glitch audio
               sl_ptr_reg <= sl_ptr_reg + 3'd1;
               if (sl_ptr_reg == 3'd4)
               begin
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
         // ram data lag the pc by one edge; consume what the last run cycle fetched
         if (fetch_reg[0])
         begin
            if (g_rdata[39:32] == `DSM_OP_PASS_L)
            begin
               acc_l_reg <= (p_rdata == 32'h0) ? in_l_reg : fmul(in_l_reg, p_rdata[27:0]);
            end
            else if (g_rdata[39:32] == `DSM_OP_PASS_R)
            begin
               acc_r_reg <= (p_rdata == 32'h0) ? in_r_reg : fmul(in_r_reg, p_rdata[27:0]);
            end
         end
         // publish once the pipeline drains; muted until clear_regs set
         if (fetch_reg == 2'b10)
         begin
            out_left <= clear_regs ? clip(acc_l_reg) : 24'h0;
            out_right <= clear_regs ? clip(acc_r_reg) : 24'h0;
            out_valid <= 1'b1;
         end
      end
   end
endmodule

// [hdl/dsm_consts.vh]
// constants for the dsp core memory and safeload block
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
`define DSM_SAMPLE_W 24
`define DSM_CORE_W 28
`define DSM_HEADROOM 4
`define DSM_PARAM_W 32
`define DSM_PROG_W 40
`define DSM_ADDR_W 11
`define DSM_MEM_AW 10
`define DSM_PARAM_BASE 11'h000
`define DSM_PARAM_LAST 11'h3ff
`define DSM_PROG_BASE 11'h400
`define DSM_PROG_LAST 11'h7ff
`define DSM_INSTR_FULL 11'h400
`define DSM_INSTR_DOUBLE 11'h200
`define DSM_INSTR_QUAD 11'h100
`define DSM_SL_DEPTH 5
`define DSM_UNITY 32'h00800000
`define DSM_SAT_POS 24'h7fffff
`define DSM_SAT_NEG 24'h800000
`define DSM_RATE_SINGLE 2'h0
`define DSM_RATE_DOUBLE 2'h1
`define DSM_RATE_QUAD 2'h2
`define DSM_OP_PASS_L 8'h01
`define DSM_OP_PASS_R 8'h02
`define DSM_OP_NOP 8'h00
`endif

// [hdl/dsm_ram.v]
// single port ram with registered read data
`timescale 1ns/100ps
module dsm_ram #(
   parameter DW = 32,
   parameter AW = 10
) (
   input wire ref_clk, // core clock
   input wire we, // write strobe
   input wire [AW-1:0] addr, // word address
   input wire [DW-1:0] wdata, // write data
   output reg [DW-1:0] rdata // registered read data
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // read first, old word out next cycle on a write; no reset so it maps to block ram
   always @(posedge ref_clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// [testbench/dsm_core_mem_properties.sv]
// port checks for the core memory and safeload block
`timescale 1ns/100ps
module dsm_core_mem_properties (
   input wire ref_clk, // clock
   input wire rst_n, // reset
   input wire frame_start, // frame pulse
   input wire [1:0] rate_sel, // budget
   input wire clear_regs, // output enable
   input wire host_start, // latch
   input wire [10:0] host_addr, // address
   input wire host_wr, // write
   input wire host_rd, // read
   input wire sl_commit, // commit
   input wire [39:0] host_rdata, // read data
   input wire host_rvalid, // read valid
   input wire [23:0] out_left, // left
   input wire [23:0] out_right, // right
   input wire out_valid, // sample done
   input wire core_ready, // booted
   input wire sl_pending // waiting
);
   // ==========
   // helper state: boot age, run countdown, host address
   reg [10:0] age_reg;
   reg [10:0] run_reg;
   reg [10:0] ptr_reg;
   wire [10:0] budget = (rate_sel == 2'h1) ? 11'h200 : (rate_sel == 2'h2) ? 11'h100 : 11'h400;
   // countdown only arms in idle, as a busy core ignores frames
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         age_reg <= 11'h0;
         run_reg <= 11'h0;
         ptr_reg <= 11'h0;
      end
      else
      begin
         if (age_reg != 11'h7ff)
            age_reg <= age_reg + 11'h1;
         if (frame_start && core_ready && !sl_pending && run_reg == 11'h0)
            run_reg <= budget + 11'h3;
         else if (run_reg != 11'h0)
            run_reg <= run_reg - 11'h1;
         if (host_start)
            ptr_reg <= host_addr;
         else if (host_wr || host_rd)
            ptr_reg <= ptr_reg + 11'h1;
      end
   end
   // ==========
   // assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_boot_ready: assert property (core_ready == (age_reg >= 11'h400))
      else $error("core ready at wrong cycle");
   a_run_length: assert property (out_valid == (run_reg == 11'h1))
      else $error("sample finished at wrong cycle");
   a_read_answer: assert property (host_rd && core_ready |-> ##2 host_rvalid)
      else $error("read not answered");
   a_read_cause: assert property (host_rvalid |-> $past(host_rd, 2))
      else $error("read data without request");
   a_param_pad: assert property (host_rvalid && $past(ptr_reg, 2) <= 11'h3ff |-> host_rdata[39:28] == 12'h0)
      else $error("parameter word not zero padded");
   a_mute_out: assert property (out_valid && !clear_regs |-> {out_left, out_right} == 48'h0)
      else $error("muted output not zero");
   a_out_hold: assert property (!$stable({out_left, out_right}) |-> out_valid)
      else $error("output changed without new sample");
   a_sl_start: assert property (sl_commit && core_ready |=> sl_pending)
      else $error("commit request not flagged");
   a_sl_finish: assert property ($rose(sl_pending) && run_reg == 11'h0 |-> ##[1:8] !sl_pending)
      else $error("idle commit too slow");
   a_sl_idle: assert property ($fell(sl_pending) |-> run_reg == 11'h0)
      else $error("commit finished while core busy");
endmodule
bind dsm_core_mem dsm_core_mem_properties chk (.ref_clk(ref_clk), .rst_n(rst_n), .frame_start(frame_start),
   .rate_sel(rate_sel), .clear_regs(clear_regs), .host_start(host_start), .host_addr(host_addr),
   .host_wr(host_wr), .host_rd(host_rd), .sl_commit(sl_commit), .host_rdata(host_rdata),
   .host_rvalid(host_rvalid), .out_left(out_left), .out_right(out_right), .out_valid(out_valid),
   .core_ready(core_ready), .sl_pending(sl_pending));

// [testbench/dsm_host_model.sv]
// host controller model on the direct memory access port
`timescale 1ns/100ps
module dsm_host_model (
   input wire ref_clk, // core clock
   output reg host_start, // latch address
   output reg [10:0] host_addr, // burst start
   output reg host_wr, // write pulse
   output reg host_rd, // read pulse
   output reg [39:0] host_wdata, // write word
   output reg clear_regs // output enable
);
   // ==========
   // quiet port, muted as after power-up
   initial
   begin
      host_start = 1'b0;
      host_addr = 11'h0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 40'h0;
      clear_regs = 1'b0;
   end
   // ==========
   // transfers; callers enter just after a clock edge
   task go(input [10:0] a);
   begin
      host_start = 1'b1;
      host_addr = a;
      @(posedge ref_clk);
      #1;
      host_start = 1'b0;
      host_addr = ~a; // released lines never keep the old value
   end
   endtask
   // strobe stays up between transfers so bursts run back to back
   task xfer(input w, input [39:0] d);
   begin
      host_wr = w;
      host_rd = !w;
      host_wdata = d;
      @(posedge ref_clk);
      #1;
   end
   endtask
   // ends a burst
   task idle;
   begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = ~host_wdata;
      @(posedge ref_clk);
      #1;
   end
   endtask
   // mute before direct loads so half-written tables stay silent
   task run(input on);
   begin
      clear_regs = on;
   end
   endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the core memory and safeload block
`timescale 1ns/100ps
`include "dsm_consts.vh"
`define CHK(nm, e, g) \
   begin \
      comparisons = comparisons + 1; \
      if ((e) !== (g)) \
      begin \
         err_count = err_count + 1; \
         $display("MISMATCH %s expected %h seen %h", nm, e, g); \
      end \
   end
module testbench;
   reg ref_clk, rst_n, frame_start, sl_load, sl_commit;
   reg [1:0] rate_sel;
   reg [23:0] in_left, in_right, l, s;
   reg [2:0] sl_index;
   reg [9:0] sl_addr;
   reg [31:0] sl_data;
   wire host_start, host_wr, host_rd, clear_regs, host_rvalid, out_valid, core_ready, sl_pending;
   wire [10:0] host_addr;
   wire [39:0] host_wdata, host_rdata;
   wire [23:0] out_left, out_right;
   integer err_count, comparisons, i, n;
   logic [39:0] rd_q[$], rm_q[$], ev, mv;
   logic [47:0] au_q[$], ea;
   logic [39:0] wv[0:2];
   logic [31:0] sd[0:4];
   logic [9:0] sa[0:4];
   dsm_host_model host (.ref_clk(ref_clk), .host_start(host_start), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .clear_regs(clear_regs));
   dsm_core_mem dut (.ref_clk(ref_clk), .rst_n(rst_n), .frame_start(frame_start), .rate_sel(rate_sel),
      .clear_regs(clear_regs), .in_left(in_left), .in_right(in_right), .host_start(host_start),
      .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .sl_load(sl_load),
      .sl_index(sl_index), .sl_addr(sl_addr), .sl_data(sl_data), .sl_commit(sl_commit),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .out_left(out_left), .out_right(out_right),
      .out_valid(out_valid), .core_ready(core_ready), .sl_pending(sl_pending));
   // 100 mhz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // watcher: each result takes the oldest note; an empty queue yields x and fails
   always @(posedge ref_clk)
   begin
      if (host_rvalid === 1'b1)
      begin
         ev = (rd_q.size() != 0) ? rd_q.pop_front() : 40'hx;
         mv = (rm_q.size() != 0) ? rm_q.pop_front() : 40'h0;
         `CHK("host read", ev, host_rdata & mv)
      end
      if (out_valid === 1'b1)
      begin
         ea = (au_q.size() != 0) ? au_q.pop_front() : 48'hx;
         `CHK("audio out", ea, {out_left, out_right})
      end
   end
   // ==========
   // helpers
   task tally_and_finish;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   task rd(input [39:0] e, input [39:0] m);
   begin
      rd_q.push_back(e);
      rm_q.push_back(m);
      host.xfer(1'b0, 40'h0);
   end
   endtask
   // bounded wait for all notes to be checked and safeload to finish
   task drain;
   begin
      n = 0;
      while ((rd_q.size() + au_q.size() != 0 || sl_pending !== 1'b0) && n < 3000)
      begin
         @(posedge ref_clk);
         #1;
         n = n + 1;
      end
      if (n >= 3000)
      begin
         err_count = err_count + 1;
         tally_and_finish;
      end
      repeat (3) @(posedge ref_clk);
      #1;
   end
   endtask
   // samples held until the next frame
   task frame(input [1:0] r, input [23:0] a, input [23:0] b, input [47:0] e);
   begin
      au_q.push_back(e);
      rate_sel = r;
      in_left = a;
      in_right = b;
      frame_start = 1'b1;
      @(posedge ref_clk);
      #1;
      frame_start = 1'b0;
   end
   endtask
   // ==========
   // main sequence
   initial
   begin
      rst_n = 1'b0;
      frame_start = 1'b0;
      rate_sel = 2'h0;
      in_left = 24'h0;
      in_right = 24'h0;
      sl_load = 1'b0;
      sl_index = 3'h0;
      sl_addr = 10'h0;
      sl_data = 32'h0;
      sl_commit = 1'b0;
      err_count = 0;
      comparisons = 0;
      n = $urandom(32'he5346176);
      repeat (20) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      n = 0;
      while (core_ready !== 1'b1 && n < 2000)
      begin
         @(posedge ref_clk);
         #1;
         n = n + 1;
      end
      `CHK("boot cycles", 1024, n)
      `CHK("outputs after reset", 48'h0, {out_left, out_right})
      if (n >= 2000)
         tally_and_finish;
      host.go(11'h3ff);
      rd(40'h0, {40{1'b1}});
      rd(40'h01_0000_0000, 40'hff_0000_0000);
      rd(40'h02_0000_0000, 40'hff_0000_0000);
      host.idle;
      drain;
      $display("test boot contents done");
      // burst from the last program word wrapping into parameters
      host.run(1'b0);
      host.go(11'h7ff);
      for (i = 0; i < 3; i = i + 1)
      begin
         wv[i] = {8'($urandom), 32'($urandom)};
         host.xfer(1'b1, wv[i]);
      end
      host.idle;
      host.go(11'h7ff);
      rd(wv[0], {40{1'b1}});
      rd({12'h0, wv[1][27:0]}, {40{1'b1}});
      rd({12'h0, wv[2][27:0]}, {40{1'b1}});
      host.idle;
      drain;
      host.go(11'h7ff);
      host.xfer(1'b1, {`DSM_OP_NOP, 32'h0});
      host.xfer(1'b1, {8'h0, `DSM_UNITY});
      host.xfer(1'b1, 40'h0);
      host.idle;
      host.run(1'b1);
      $display("test direct burst done");
      // pass-through at every rate, then one muted frame
      for (i = 0; i < 5; i = i + 1)
      begin
         l = 24'($urandom);
         s = 24'($urandom);
         if (i == 4)
            host.run(1'b0);
         frame(i[1:0], l, s, (i == 4) ? 48'h0 : {l, s});
         drain;
      end
      host.run(1'b1);
      $display("test rates and mute done");
      // five entries plus a stray index, committed while a frame runs
      sa[0] = 10'h0;
      sd[0] = 32'h01000000;
      sa[1] = 10'h1;
      sd[1] = 32'h0f800000;
      for (i = 2; i < 5; i = i + 1)
      begin
         sa[i] = 10'(128 * i + ($urandom & 127));
         sd[i] = {4'h0, 28'($urandom)};
      end
      for (i = 0; i < 6; i = i + 1)
      begin
         sl_load = 1'b1;
         sl_index = (i < 5) ? i[2:0] : 3'(5 + ($urandom % 3));
         sl_addr = (i < 5) ? sa[i] : 10'h1;
         sl_data = (i < 5) ? sd[i] : 32'h00400000;
         @(posedge ref_clk);
         #1;
      end
      sl_load = 1'b0;
      sl_addr = ~sl_addr;
      frame(2'($urandom), 24'h123456, 24'h654321, {24'h123456, 24'h654321});
      sl_commit = 1'b1;
      @(posedge ref_clk);
      #1;
      sl_commit = 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK("commit waits", 1'b1, sl_pending)
      drain;
      host.go(11'h0);
      rd({8'h0, sd[0]}, {40{1'b1}});
      rd({8'h0, sd[1]}, {40{1'b1}});
      host.idle;
      for (i = 2; i < 5; i = i + 1)
      begin
         host.go({1'b0, sa[i]});
         rd({8'h0, sd[i]}, {40{1'b1}});
         host.idle;
      end
      host.go(11'h400);
      rd(40'h01_0000_0000, 40'hff_0000_0000);
      host.idle;
      drain;
      $display("test safeload done");
      // gains of 2.0 and -1.0 push sign-extended inputs into the clipper
      frame(2'($urandom), 24'h600000, 24'h800000, {`DSM_SAT_POS, `DSM_SAT_POS});
      drain;
      frame(2'h1, 24'ha00000, 24'h100000, {`DSM_SAT_NEG, 24'hf00000});
      drain;
      $display("test clipping done");
      // commit while idle: one entry restores unity gain on the left channel
      sl_load = 1'b1;
      sl_index = 3'h0;
      sl_addr = 10'h0;
      sl_data = `DSM_UNITY;
      @(posedge ref_clk);
      #1;
      sl_load = 1'b0;
      sl_commit = 1'b1;
      @(posedge ref_clk);
      #1;
      sl_commit = 1'b0;
      drain;
      host.go(11'h0);
      rd({8'h0, `DSM_UNITY}, {40{1'b1}});
      host.idle;
      l = 24'($urandom);
      frame(2'($urandom), l, 24'h0, {l, 24'h0});
      drain;
      $display("test idle commit done");
      tally_and_finish;
   end
endmodule
